// ---- audio_fifo_cdrom_sector_codec.sv ----
// Purpose: Transmit/receive audio FIFOs with start-up hold, tick, and sector encoder/decoder
// Assumes: APB slave, one wait state per access; serial side gives one request per sample pair
// Notes:   Sector encoder feeds the transmit FIFO, the decoder is fed by the receive side
//
// Summary of operation
// - After transmit reset release, FIFO holds one sample and waits for first write.
// - First write releases the hold and starts transmission of FIFO contents.
// - Receive FIFO leaves reset only when software clears its reset bit.
// - Each FIFO stores at most six left/right sample pairs.
// - Empty flag raised when exactly one sample pair remains outside reset and the start-up hold.
// - Underrun flag raised when a sample is due and FIFO is empty.
// - On underrun the last sample keeps repeating until new data arrives.
// - Tick fires every programmed number of sample pairs, regardless of FIFO state.
// - Encoder and decoder run fully independently.
// - One 16-bit read/write control register configures both, resetting to zero.
// - Bits 15:14 select decoder swap, zero meaning pass-through.
// - Bit 13 enables decoder sync recognition.
// - Bit 11 enables decoder descrambling.
// - Bits 10:9 select decoder CRC check: none, mode 1, mode 2 form 1/2.
// - Bits 7:6 select encoder swap with the same coding.
// - Bit 5 enables encoder sync recognition.
// - Bit 3 enables encoder scrambling.
// - Bits 2:1 select encoder CRC insertion mode.
// - Sector restarts at sync when enabled, else 2352 bytes after previous start.
// - Inserted CRC overwrites whatever software wrote in the CRC slot.
// - Swap codes: pass, exchange halves, swap bytes in halves, reverse bytes.
// - Encoder order is CRC insertion, then scrambling, then swapping.
`timescale 1ns/1ps

module sector_stage
	import sector_codec_pkg::*;
#(
	parameter bit ENCODE = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        in_valid,
	input  wire logic [31:0] in_word,
	input  wire logic        sync_en,
	input  wire logic        scram_en,
	input  wire crc_mode_e   mode,
	input  wire swap_e       swap,
	output logic             out_valid,
	output logic [31:0]      out_word,
	output logic             no_sync,
	output logic             il_sync,
	output logic             crc_err
);
	logic [9:0]  idx_q;
	logic [31:0] prev1_q;
	logic [31:0] prev2_q;
	logic [31:0] crc_q;
	logic [14:0] lfsr_q;

	wire         sync_hit  = sync_en && prev2_q == SYNC_W0 && prev1_q == SYNC_W1 && in_word == SYNC_W2;
	wire [9:0]   eff_idx   = sync_hit ? IDX_SYNC_END : idx_q;
	wire [9:0]   crc_pos   = (mode == CRC_MODE1) ? CRC_POS_M1 : (mode == CRC_M2F1) ? CRC_POS_M2F1 : CRC_POS_M2F2;
	wire [9:0]   crc_first = (mode == CRC_MODE1) ? 10'h000 : IDX_M2_FIRST;
	wire [14:0]  lfsr_cur  = (eff_idx == IDX_SCRAM_FIRST) ? LFSR_SEED : lfsr_q;
	wire [46:0]  scr       = scramble_step(lfsr_cur);
	wire         scr_on    = scram_en && eff_idx >= IDX_SCRAM_FIRST;
	wire         crc_slot  = mode != CRC_NONE && eff_idx == crc_pos;
	// Sync found late still needs the two earlier sync words folded in for mode 1
	wire [31:0]  crc_in    = sync_hit ? edc_word(edc_word(32'h0000_0000, SYNC_W0), SYNC_W1) :
	                         (eff_idx == crc_first) ? 32'h0000_0000 : crc_q;
	wire [31:0]  crc_word  = swap_word(crc_in, SWAP_REVERSE);
	wire [31:0]  descr     = scr_on ? in_word ^ scr[31:0] : in_word;
	wire [31:0]  plain     = ENCODE ? (crc_slot ? crc_word : in_word) : descr;
	wire [31:0]  line_word = (ENCODE && scr_on) ? plain ^ scr[31:0] : plain;
	wire [9:0]   idx_next  = (eff_idx == IDX_LAST) ? 10'h000 : eff_idx + 10'h001;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_q     <= 10'h000;
			prev1_q   <= 32'h0000_0000;
			prev2_q   <= 32'h0000_0000;
			crc_q     <= 32'h0000_0000;
			lfsr_q    <= LFSR_SEED;
			out_valid <= 1'b0;
			out_word  <= 32'h0000_0000;
			no_sync   <= 1'b0;
			il_sync   <= 1'b0;
			crc_err   <= 1'b0;
		end else begin
			out_valid <= in_valid;
			no_sync   <= in_valid && eff_idx == IDX_SYNC_END && !sync_hit;
			il_sync   <= in_valid && sync_hit && idx_q != IDX_SYNC_END;
			crc_err   <= in_valid && !ENCODE && crc_slot && plain != crc_word;
			if (in_valid) begin
				idx_q    <= idx_next;
				prev2_q  <= prev1_q;
				prev1_q  <= in_word;
				crc_q    <= edc_word(crc_in, plain);
				lfsr_q   <= scr[46:32];
				out_word <= swap_word(line_word, swap);
			end
		end
	end

	a_sector_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		in_valid && !sync_hit && idx_q == IDX_LAST |=> idx_q == 10'h000)
		else $error("sector index did not wrap after 2352 bytes");
endmodule

module audio_fifo_cdrom_sector_codec
	import sector_codec_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tx_sample_req,
	output sample_s          tx_sample,
	output logic             tx_running,
	output logic             tx_empty_irq,
	output logic             tx_underrun_irq,
	output logic             periodic_sample_tick_irq,
	input  wire logic        rx_sample_valid,
	input  wire sample_s     rx_sample
);
	logic        rst_meta_q;
	logic        rst_n_q;
	logic [7:0]  fifo_ctrl_q;
	codec_ctrl_s codec_ctrl_q;
	logic [31:0] tx_mem_q [FIFO_DEPTH];
	logic [31:0] rx_mem_q [FIFO_DEPTH];
	logic [2:0]  tx_rd_q, tx_wr_q, tx_cnt_q;
	logic [2:0]  rx_rd_q, rx_wr_q, rx_cnt_q;
	logic        tx_held_q, tx_ovr_q, rx_ovr_q, rx_pop_ok_q;
	logic [3:0]  tick_cnt_q;
	logic [3:0]  status_q;
	logic        dec_crc_flag_q;
	logic        enc_valid, enc_nosync, enc_ilsync;
	logic        dec_valid, dec_nosync, dec_ilsync, dec_crcerr;
	logic [31:0] enc_word, dec_word;

	function automatic logic [2:0] ptr_inc(input logic [2:0] p);
		return (p == FIFO_LAST) ? 3'd0 : p + 3'd1;
	endfunction

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	wire        access    = psel && penable;
	wire        done      = access && pready;
	wire        hit_fc    = paddr == ADDR_FIFO_CTRL;
	wire        hit_st    = paddr == ADDR_STATUS;
	wire        hit_tx    = paddr == ADDR_TX_PORT3;
	wire        hit_rx    = paddr == ADDR_RX_PORT2;
	wire        hit_cc    = paddr == ADDR_CODEC_CTRL;
	wire        mapped    = hit_fc || hit_st || hit_tx || hit_rx || hit_cc;
	wire        tx_rst    = fifo_ctrl_q[FC_TX_RST];
	wire        rx_rst    = fifo_ctrl_q[FC_RX_RST];
	wire        tick_en   = fifo_ctrl_q[FC_TICK_EN];
	wire [3:0]  tick_n    = fifo_ctrl_q[FC_TICK_LSB +: 4];
	wire        tx_write  = done && pwrite && hit_tx && !tx_rst;
	wire        tx_pop    = tx_sample_req && !tx_held_q && !tx_rst && tx_cnt_q != 3'd0;
	wire        tx_starve = tx_sample_req && !tx_held_q && !tx_rst && tx_cnt_q == 3'd0;
	wire        tx_push   = enc_valid && !tx_rst && (tx_cnt_q != FIFO_DEPTH || tx_pop);
	wire        rx_pop    = done && !pwrite && hit_rx && rx_pop_ok_q;
	wire        rx_push   = dec_valid && !rx_rst && (rx_cnt_q != FIFO_DEPTH || rx_pop);
	// Compare with >= so a smaller count written mid-period still fires instead of wrapping
	wire        tick_hit  = tx_sample_req && tick_en && tick_n != 4'h0 && tick_cnt_q >= tick_n - 4'h1;
	wire [31:0] status_w  = {9'h000, dec_crc_flag_q, status_q[3], status_q[2], 2'b00,
	                         status_q[1], status_q[0], 4'h0, rx_ovr_q, rx_cnt_q, 2'b00, tx_ovr_q,
	                         tx_underrun_irq, tx_held_q, tx_cnt_q};
	wire [31:0] rd_mux    = hit_fc ? {24'h000000, fifo_ctrl_q} :
	                        hit_st ? status_w :
	                        hit_rx ? (rx_cnt_q != 3'd0 ? rx_mem_q[rx_rd_q] : 32'h0000_0000) :
	                        hit_cc ? {16'h0000, codec_ctrl_q} : 32'h0000_0000;


	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			prdata       <= 32'h0000_0000;
			rx_pop_ok_q  <= 1'b0;
			fifo_ctrl_q  <= FIFO_CTRL_RESET;
			codec_ctrl_q <= CODEC_CTRL_RESET;
		end else begin
			pready      <= access && !pready;
			pslverr     <= access && !pready && !mapped;
			prdata      <= (access && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
			rx_pop_ok_q <= access && !pready && rx_cnt_q != 3'd0;
			if (done && pwrite && hit_fc)
				fifo_ctrl_q <= pwdata[7:0] & FIFO_CTRL_MASK;
			if (done && pwrite && hit_cc)
				codec_ctrl_q <= pwdata[15:0] & CODEC_CTRL_MASK;
		end
	end

	// Encoder and decoder share only the control register, no state
	sector_stage #(.ENCODE(1'b1)) u_encoder (
		.clk       (clk),
		.rst_n     (rst_n_q),
		.in_valid  (tx_write),
		.in_word   (pwdata),
		.sync_en   (codec_ctrl_q.enc_sync_en),
		.scram_en  (codec_ctrl_q.enc_scramble),
		.mode      (codec_ctrl_q.enc_mode),
		.swap      (codec_ctrl_q.enc_swap),
		.out_valid (enc_valid),
		.out_word  (enc_word),
		.no_sync   (enc_nosync),
		.il_sync   (enc_ilsync),
		.crc_err   ()
	);

	sector_stage #(.ENCODE(1'b0)) u_decoder (
		.clk       (clk),
		.rst_n     (rst_n_q),
		.in_valid  (rx_sample_valid),
		.in_word   (rx_sample),
		.sync_en   (codec_ctrl_q.dec_sync_en),
		.scram_en  (codec_ctrl_q.dec_descramble),
		.mode      (codec_ctrl_q.dec_mode),
		.swap      (codec_ctrl_q.dec_swap),
		.out_valid (dec_valid),
		.out_word  (dec_word),
		.no_sync   (dec_nosync),
		.il_sync   (dec_ilsync),
		.crc_err   (dec_crcerr)
	);

	// Transmit FIFO; reset parks it at one stale sample until software writes
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int i = 0; i < FIFO_DEPTH; i++)
				tx_mem_q[i] <= 32'h0000_0000;
			tx_rd_q         <= 3'd0;
			tx_wr_q         <= TX_HELD_LEVEL;
			tx_cnt_q        <= TX_HELD_LEVEL;
			tx_held_q       <= 1'b1;
			tx_ovr_q        <= 1'b0;
			tx_underrun_irq <= 1'b0;
			tx_empty_irq    <= 1'b0;
			tx_running      <= 1'b0;
			tx_sample       <= '0;
		end else begin
			tx_empty_irq <= !tx_held_q && !tx_rst && tx_cnt_q == 3'd1;
			tx_running   <= !tx_held_q && !tx_rst;
			if (tx_rst) begin
				tx_rd_q         <= 3'd0;
				tx_wr_q         <= TX_HELD_LEVEL;
				tx_cnt_q        <= TX_HELD_LEVEL;
				tx_held_q       <= 1'b1;
				tx_ovr_q        <= 1'b0;
				tx_underrun_irq <= 1'b0;
			end else begin
				if (tx_push) begin
					tx_mem_q[tx_wr_q] <= enc_word;
					tx_wr_q           <= ptr_inc(tx_wr_q);
				end
				if (tx_pop) begin
					tx_sample <= tx_mem_q[tx_rd_q];
					tx_rd_q   <= ptr_inc(tx_rd_q);
				end
				tx_cnt_q <= tx_cnt_q + {2'b00, tx_push} - {2'b00, tx_pop};
				if (enc_valid)
					tx_held_q <= 1'b0;
				if (enc_valid && !tx_push)
					tx_ovr_q <= 1'b1;
				// A starve in the same cycle as a write still flags the underrun
				if (tx_starve)
					tx_underrun_irq <= 1'b1;
				else if (enc_valid)
					tx_underrun_irq <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int i = 0; i < FIFO_DEPTH; i++)
				rx_mem_q[i] <= 32'h0000_0000;
			rx_rd_q  <= 3'd0;
			rx_wr_q  <= 3'd0;
			rx_cnt_q <= 3'd0;
			rx_ovr_q <= 1'b0;
		end else if (rx_rst) begin
			rx_rd_q  <= 3'd0;
			rx_wr_q  <= 3'd0;
			rx_cnt_q <= 3'd0;
			rx_ovr_q <= 1'b0;
		end else begin
			if (rx_push) begin
				rx_mem_q[rx_wr_q] <= dec_word;
				rx_wr_q           <= ptr_inc(rx_wr_q);
			end
			if (rx_pop)
				rx_rd_q <= ptr_inc(rx_rd_q);
			rx_cnt_q <= rx_cnt_q + {2'b00, rx_push} - {2'b00, rx_pop};
			if (dec_valid && !rx_push)
				rx_ovr_q <= 1'b1;
		end
	end

	// Tick counts sample pairs even while the transmit FIFO is held in reset
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick_cnt_q               <= 4'h0;
			periodic_sample_tick_irq <= 1'b0;
			status_q                 <= 4'h0;
			dec_crc_flag_q           <= 1'b0;
		end else begin
			periodic_sample_tick_irq <= tick_hit;
			if (!tick_en)
				tick_cnt_q <= 4'h0;
			else if (tick_sample_step(tx_sample_req))
				tick_cnt_q <= tick_hit ? 4'h0 : tick_cnt_q + 4'h1;
			if (enc_nosync || enc_ilsync)
				status_q[1:0] <= {enc_ilsync, enc_nosync};
			if (dec_nosync || dec_ilsync)
				status_q[3:2] <= {dec_ilsync, dec_nosync};
			if (dec_crcerr)
				dec_crc_flag_q <= 1'b1;
			else if (dec_nosync || dec_ilsync)
				dec_crc_flag_q <= 1'b0;
		end
	end

	function automatic logic tick_sample_step(input logic req);
		return req;
	endfunction

	a_held_one_sample: assert property (@(posedge clk) disable iff (!rst_n_q)
		tx_rst |=> tx_cnt_q == TX_HELD_LEVEL && tx_held_q)
		else $error("transmit FIFO not parked at one sample");
	// Write edge, encoder stage, FIFO push: hold drops two edges after the write, running one later
	a_first_write_go: assert property (@(posedge clk) disable iff (!rst_n_q)
		tx_held_q && !tx_rst && tx_write ##1 !tx_rst [*3] |-> !tx_held_q ##1 tx_running)
		else $error("first write did not release transmit hold");
	a_rx_stays_reset: assert property (@(posedge clk) disable iff (!rst_n_q)
		rx_rst && $past(rx_rst) |-> rx_cnt_q == 3'd0)
		else $error("receive FIFO filled while in reset");
	a_fifo_depth: assert property (@(posedge clk) disable iff (!rst_n_q)
		tx_cnt_q <= FIFO_DEPTH && rx_cnt_q <= FIFO_DEPTH)
		else $error("FIFO level above six");
	a_empty_flag: assert property (@(posedge clk) disable iff (!rst_n_q)
		tx_running && !tx_rst && tx_cnt_q == 3'd1 |=> tx_empty_irq)
		else $error("empty flag missing at one sample left");
	a_underrun_flag: assert property (@(posedge clk) disable iff (!rst_n_q)
		tx_starve |=> tx_underrun_irq)
		else $error("underrun not flagged");
	a_repeat_last: assert property (@(posedge clk) disable iff (!rst_n_q)
		tx_starve |=> $stable(tx_sample))
		else $error("sample changed during underrun");
	a_tick_period: assert property (@(posedge clk) disable iff (!rst_n_q)
		tick_en && tick_n == 4'h1 && tx_sample_req && $past(tick_en) |=> periodic_sample_tick_irq)
		else $error("tick missed for single pair period");
	a_tick_source: assert property (@(posedge clk) disable iff (!rst_n_q)
		periodic_sample_tick_irq |-> $past(tx_sample_req) && $past(tick_en))
		else $error("tick fired without a counted sample pair");
	a_ctrl_readback: assert property (@(posedge clk) disable iff (!rst_n_q)
		done && pwrite && hit_cc |=> codec_ctrl_q == ($past(pwdata[15:0]) & CODEC_CTRL_MASK))
		else $error("control register write not stored");
endmodule

// ---- sector_codec_pkg.sv ----
// Purpose: Shared constants, types and helpers for the audio FIFO and sector codec block
// Assumes: 32-bit APB register bus, one 32-bit word holds one left/right sample pair
// Notes:   Byte 0 of a sector word sits in bits 31:24
package sector_codec_pkg;

	localparam logic [7:0]  ADDR_FIFO_CTRL  = 8'h00;
	localparam logic [7:0]  ADDR_STATUS     = 8'h04;
	localparam logic [7:0]  ADDR_TX_PORT3   = 8'h08;
	localparam logic [7:0]  ADDR_RX_PORT2   = 8'h0c;
	localparam logic [7:0]  ADDR_CODEC_CTRL = 8'hc8;

	localparam logic [7:0]  FIFO_CTRL_RESET  = 8'h03;
	localparam logic [7:0]  FIFO_CTRL_MASK   = 8'hf7;
	localparam logic [15:0] CODEC_CTRL_RESET = 16'h0000;
	localparam logic [15:0] CODEC_CTRL_MASK  = 16'heeee;
	localparam int          FC_TX_RST        = 0;
	localparam int          FC_RX_RST        = 1;
	localparam int          FC_TICK_EN       = 2;
	localparam int          FC_TICK_LSB      = 4;

	localparam int          ST_TX_CNT_LSB    = 0;
	localparam int          ST_TX_HELD       = 3;
	localparam int          ST_TX_UNDERRUN   = 4;
	localparam int          ST_TX_OVERRUN    = 5;
	localparam int          ST_RX_CNT_LSB    = 8;
	localparam int          ST_RX_OVERRUN    = 11;
	localparam int          ST_ENC_NOSYNC    = 16;
	localparam int          ST_ENC_ILSYNC    = 17;
	localparam int          ST_DEC_NOSYNC    = 20;
	localparam int          ST_DEC_ILSYNC    = 21;
	localparam int          ST_DEC_CRCERR    = 22;

	localparam logic [2:0]  FIFO_DEPTH       = 3'd6;
	localparam logic [2:0]  FIFO_LAST        = 3'd5;
	localparam logic [2:0]  TX_HELD_LEVEL    = 3'd1;

	localparam int          SECTOR_BYTES     = 2352;
	localparam logic [9:0]  IDX_LAST         = 10'(SECTOR_BYTES / 4 - 1);
	localparam logic [9:0]  IDX_SYNC_END     = 10'h002;
	localparam logic [9:0]  IDX_SCRAM_FIRST  = 10'h003;
	localparam logic [9:0]  IDX_M2_FIRST     = 10'h004;
	localparam logic [9:0]  CRC_POS_M1       = 10'h204;
	localparam logic [9:0]  CRC_POS_M2F1     = 10'h206;
	localparam logic [9:0]  CRC_POS_M2F2     = 10'h24b;

	localparam logic [31:0] SYNC_W0          = 32'h00ff_ffff;
	localparam logic [31:0] SYNC_W1          = 32'hffff_ffff;
	localparam logic [31:0] SYNC_W2          = 32'hffff_ff00;
	localparam logic [14:0] LFSR_SEED        = 15'h0001;
	localparam logic [31:0] EDC_POLY         = 32'hd801_8001;

	typedef enum logic [1:0] {SWAP_NONE, SWAP_HALVES, SWAP_BYTES, SWAP_REVERSE} swap_e;
	typedef enum logic [1:0] {CRC_NONE, CRC_MODE1, CRC_M2F1, CRC_M2F2} crc_mode_e;

	typedef struct packed {
		swap_e     dec_swap;
		logic      dec_sync_en;
		logic      rsv12;
		logic      dec_descramble;
		crc_mode_e dec_mode;
		logic      rsv8;
		swap_e     enc_swap;
		logic      enc_sync_en;
		logic      rsv4;
		logic      enc_scramble;
		crc_mode_e enc_mode;
		logic      rsv0;
	} codec_ctrl_s;

	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
	} sample_s;

	function automatic logic [31:0] swap_word(input logic [31:0] w, input swap_e mode);
		case (mode)
			SWAP_HALVES:  return {w[15:0], w[31:16]};
			SWAP_BYTES:   return {w[23:16], w[31:24], w[7:0], w[15:8]};
			SWAP_REVERSE: return {w[7:0], w[15:8], w[23:16], w[31:24]};
			default:      return w;
		endcase
	endfunction

	// Reflected EDC, each byte taken least significant bit first
	function automatic logic [31:0] edc_word(input logic [31:0] crc, input logic [31:0] w);
		logic [31:0] c;
		c = crc;
		for (int i = 0; i < 32; i++) begin
			c = (c >> 1) ^ ((c[0] ^ w[24 - 8 * (i / 8) + (i % 8)]) ? EDC_POLY : 32'h0000_0000);
		end
		return c;
	endfunction

	// Returns {next state, 32-bit mask} of the x^15+x+1 scrambler
	function automatic logic [46:0] scramble_step(input logic [14:0] s);
		logic [14:0] st;
		logic [31:0] m;
		st = s;
		m = 32'h0000_0000;
		for (int i = 0; i < 32; i++) begin
			m[24 - 8 * (i / 8) + (i % 8)] = st[0];
			st = {st[0] ^ st[1], st[14:1]};
		end
		return {st, m};
	endfunction

endpackage

// ---- audio_serial_model.sv ----
// Purpose: Serial audio side: sample requests from the transmitter, words from the receiver
// Assumes: Called from the bench; one request or one received word per call
// Notes:   Requests are spaced by whole word clocks, never back to back
`timescale 1ns/1ps
module audio_serial_model
	import sector_codec_pkg::*;
(
	input  wire logic clk,
	output logic      tx_sample_req,
	output logic      rx_sample_valid,
	output sample_s   rx_sample
);
	initial begin
		tx_sample_req = 1'b0;
		rx_sample_valid = 1'b0;
		rx_sample = '0;
	end
	// Even spacing keeps software refills inside one sample period
	task automatic request();
		@(posedge clk);
		tx_sample_req <= 1'b1;
		@(posedge clk);
		tx_sample_req <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic send(input logic [31:0] w);
		@(posedge clk);
		rx_sample_valid <= 1'b1;
		rx_sample <= w;
		@(posedge clk);
		rx_sample_valid <= 1'b0;
		// Data is not held past its strobe
		rx_sample <= ~w;
	endtask
endmodule

// ---- audio_fifo_cdrom_sector_codec_bench.sv ----
// Purpose: Self-checking bench for the audio FIFO and sector codec block
// Assumes: APB master tasks wait on pready; serial side comes from the model
// Notes:   Scramble and CRC stay off so swaps show directly; decoder sync is used for sector alignment
`timescale 1ns/1ps
module audio_fifo_cdrom_sector_codec_bench
	import sector_codec_pkg::*;
;
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata, w;
	logic        tx_running, tx_empty_irq, tx_underrun_irq, tick, tx_sample_req, rx_sample_valid;
	sample_s     tx_sample, rx_sample;
	logic [31:0] exp_q [4];
	int          miscompares, checked, ticks;

	audio_fifo_cdrom_sector_codec dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_sample_req(tx_sample_req), .tx_sample(tx_sample),
		.tx_running(tx_running), .tx_empty_irq(tx_empty_irq), .tx_underrun_irq(tx_underrun_irq),
		.periodic_sample_tick_irq(tick), .rx_sample_valid(rx_sample_valid), .rx_sample(rx_sample));
	audio_serial_model m_u (.clk(clk), .tx_sample_req(tx_sample_req),
		.rx_sample_valid(rx_sample_valid), .rx_sample(rx_sample));

	always #50 clk = ~clk;
	always @(posedge clk) if (tick === 1'b1) ticks++;

	function automatic logic [31:0] swp(input logic [31:0] v, input int k);
		case (k)
			1: return {v[15:0], v[31:16]};
			2: return {v[23:16], v[31:24], v[7:0], v[15:8]};
			3: return {v[7:0], v[15:8], v[23:16], v[31:24]};
			default: return v;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr_n;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0, 32'h1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk(rdata & m, exp);
	endtask

	task automatic test_done();
		$display("Counts: checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#3000000;
		miscompares++;
		test_done();
	end

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{miscompares, checked, ticks} = '0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rc(ADDR_CODEC_CTRL, 32'h0000_0000, 32'hffff_ffff);
		rc(ADDR_FIFO_CTRL, 32'h0000_0003, 32'h0000_00ff);
		wr(ADDR_CODEC_CTRL, 32'h0000_ffff);
		rc(ADDR_CODEC_CTRL, 32'h0000_eeee, 32'hffff_ffff);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(rerr), 32'h1);
		wr(ADDR_CODEC_CTRL, 32'h0000_0000);
		wr(ADDR_FIFO_CTRL, 32'h0000_0003);
		wr(ADDR_FIFO_CTRL, 32'h0000_0002);
		m_u.request();
		rc(ADDR_STATUS, 32'h0000_0009, 32'h0000_000f);
		for (int k = 0; k < 4; k++) begin
			w = {8'h10 + 8'(k), 8'h2a, 8'h3b, 8'h4c};
			exp_q[k] = swp(w, k);
			wr(ADDR_CODEC_CTRL, 32'(k) << 6);
			wr(ADDR_TX_PORT3, w);
		end
		repeat (3) @(posedge clk);
		rc(ADDR_STATUS, 32'h0000_0005, 32'h0000_000f);
		chk(32'(tx_running), 32'h1);
		wr(ADDR_FIFO_CTRL, 32'h0000_0026);
		ticks = 0;
		for (int i = 0; i < 6; i++) begin
			m_u.request();
			if (i >= 1 && i <= 4) chk(tx_sample, exp_q[i - 1]);
			if (i == 3) chk(32'(tx_empty_irq), 32'h1);
		end
		chk(32'(tx_underrun_irq), 32'h1);
		chk(tx_sample, exp_q[3]);
		chk(32'(ticks), 32'h3);
		wr(ADDR_TX_PORT3, 32'h5566_7788);
		repeat (3) @(posedge clk);
		chk(32'(tx_underrun_irq), 32'h0);
		wr(ADDR_CODEC_CTRL, 32'h0000_4000);
		m_u.send(32'ha1b2_c3d4);
		rc(ADDR_STATUS, 32'h0000_0000, 32'h0000_0700);
		wr(ADDR_FIFO_CTRL, 32'h0000_0000);
		for (int i = 0; i < 7; i++) m_u.send(32'ha1b2_c3d4 + 32'(i));
		repeat (3) @(posedge clk);
		rc(ADDR_STATUS, 32'h0000_0e00, 32'h0000_0f00);
		rc(ADDR_RX_PORT2, swp(32'ha1b2_c3d4, 1), 32'hffff_ffff);
		// Decoder has taken 8 words; a sync found at word 10 flags a bad sector length
		wr(ADDR_CODEC_CTRL, 32'h0000_6000);
		m_u.send(SYNC_W0);
		m_u.send(SYNC_W1);
		m_u.send(SYNC_W2);
		rc(ADDR_STATUS, 32'h0020_0000, 32'h0070_0000);
		// Without further syncs the next sector starts 2352 bytes on; word 2 of it finds no sync
		for (int i = 0; i < 587; i++) m_u.send(32'h0000_1000 + 32'(i));
		rc(ADDR_STATUS, 32'h0020_0000, 32'h0070_0000);
		m_u.send(32'h0000_2000);
		rc(ADDR_STATUS, 32'h0010_0000, 32'h0070_0000);
		test_done();
	end
endmodule
